// [include/wwdt_pkg.sv]
// constants shared by the windowed watchdog design
package wwdt_pkg;

    // register indices; byte address is four times the index
    localparam logic [1:0] WWDT_CTRL_INDEX    = 2'h0;
    localparam logic [1:0] WWDT_STATUS_INDEX  = 2'h1;
    localparam int         WWDT_ADDR_WIDTH    = 4;
    localparam int         WWDT_DATA_WIDTH    = 32;

    // control field layout
    localparam int         WWDT_PERIOD_LSB    = 0;
    localparam int         WWDT_WINDOW_LSB    = 4;
    localparam int         WWDT_CODE_WIDTH    = 4;
    localparam logic [7:0] WWDT_CTRL_RESET    = 8'h00;

    // status field layout
    localparam int         WWDT_BUSY_BIT      = 0;
    localparam int         WWDT_LOCK_BIT      = 7;

    // duration coding: code 1 is 8 counter ticks, each step doubles, 0xb is the last
    localparam logic [3:0]  WWDT_CODE_OFF     = 4'h0;
    localparam logic [3:0]  WWDT_CODE_MAX     = 4'hb;
    localparam int          WWDT_COUNT_WIDTH  = 14;
    localparam logic [13:0] WWDT_BASE_TICKS   = 14'h0008;

    // counter clock ticks needed to carry a write or a restart across
    localparam logic [1:0]  WWDT_SYNC_TICKS   = 2'h2;

    typedef enum logic [2:0] {
        WWDT_OFF,
        WWDT_NORMAL,
        WWDT_FIRST,
        WWDT_CLOSED,
        WWDT_OPEN
    } wwdt_state_type;

endpackage

// [hw/wwdt_tick_sync.sv]
// synchroniser and rising edge detector for the slow counter clock
`timescale 1ns/10ps
module wwdt_tick_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      tick
);
    logic meta;
    logic stable;
    logic prev;
    logic next_tick;

    // meta feeds stable only; the edge is taken from the settled stages
    always_comb begin
        next_tick = stable & ~prev;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
            tick   <= 1'b0;
        end else begin
            meta   <= async_in;
            stable <= meta;
            prev   <= stable;
            tick   <= next_tick;
        end
    end
endmodule // wwdt_tick_sync

// [hw/wwdt_top.sv]
// windowed watchdog timer with avalon register slave
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module wwdt_top (
    input  wire logic                                 clk,
    input  wire logic                                 srst,
    input  wire logic [wwdt_pkg::WWDT_ADDR_WIDTH-1:0] avs_address,
    input  wire logic                                 avs_read,
    input  wire logic                                 avs_write,
    input  wire logic [wwdt_pkg::WWDT_DATA_WIDTH-1:0] avs_writedata,
    input  wire logic [3:0]                           avs_byteenable,
    output logic      [wwdt_pkg::WWDT_DATA_WIDTH-1:0] avs_readdata,
    output logic                                      avs_waitrequest,
    input  wire logic                                 watchdog_counter_clock,
    input  wire logic                                 watchdog_restart_instruction,
    input  wire logic                                 debug_halt,
    input  wire logic                                 config_change_guard,
    input  wire logic [7:0]                           fuse_ctrl,
    input  wire logic                                 fuse_enable,
    output logic                                      system_reset_request
);
    logic                                      wdt_tick;
    logic                                      bus_ack;
    logic                                      next_bus_ack;
    logic [wwdt_pkg::WWDT_DATA_WIDTH-1:0]      next_readdata;
    logic                                      bus_req;
    logic                                      wr_taken;
    logic [1:0]                                reg_index;

    logic [7:0]                                watchdog_control;
    logic [7:0]                                next_watchdog_control;
    logic                                      lock;
    logic                                      next_lock;
    logic                                      armed;
    logic                                      next_armed;
    logic                                      fuse_done;
    logic                                      next_fuse_done;
    logic                                      sync_pending_flag;
    logic                                      next_sync_pending_flag;
    logic [1:0]                                cfg_ticks;
    logic [1:0]                                next_cfg_ticks;
    logic [3:0]                                act_period;
    logic [3:0]                                next_act_period;
    logic [3:0]                                act_window;
    logic [3:0]                                next_act_window;
    logic                                      rst_pend;
    logic                                      next_rst_pend;
    logic [1:0]                                rst_ticks;
    logic [1:0]                                next_rst_ticks;
    wwdt_pkg::wwdt_state_type                  state;
    wwdt_pkg::wwdt_state_type                  next_state;
    logic [wwdt_pkg::WWDT_COUNT_WIDTH-1:0]     counter;
    logic [wwdt_pkg::WWDT_COUNT_WIDTH-1:0]     next_counter;
    logic                                      next_reset_request;
    logic                                      cfg_apply;
    logic                                      restart_done;
    logic [wwdt_pkg::WWDT_COUNT_WIDTH-1:0]     open_limit;
    logic [wwdt_pkg::WWDT_COUNT_WIDTH-1:0]     closed_limit;
    logic                                      open_reached;
    logic                                      closed_reached;

    // duration decode; reserved codes behave as the longest one
    function automatic logic [wwdt_pkg::WWDT_COUNT_WIDTH-1:0] wwdt_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > wwdt_pkg::WWDT_CODE_MAX) ? wwdt_pkg::WWDT_CODE_MAX : code;
        wwdt_limit = wwdt_pkg::WWDT_BASE_TICKS << (c - 4'h1);
    endfunction

    // counter clock is treated as a tick enable in the system clock
    wwdt_tick_sync u_tick (
        .clk      (clk),
        .srst     (srst),
        .async_in (watchdog_counter_clock),
        .tick     (wdt_tick)
    );

    // avalon slave: one wait cycle, write lands at the edge waitrequest is low
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_taken        = avs_write & bus_ack;
    assign reg_index       = avs_address[3:2];

    always_comb begin
        next_bus_ack  = bus_req & ~bus_ack;
        next_readdata = avs_readdata;
        if (avs_read && !bus_ack) begin
            next_readdata = '0;
            // bits 3:2 are the whole decode; indices 2 and 3 read as zero
            if (reg_index == wwdt_pkg::WWDT_CTRL_INDEX) begin
                next_readdata[7:0] = watchdog_control;
            end else if (reg_index == wwdt_pkg::WWDT_STATUS_INDEX) begin
                next_readdata[wwdt_pkg::WWDT_LOCK_BIT] = lock;
                next_readdata[wwdt_pkg::WWDT_BUSY_BIT] = sync_pending_flag;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_ack      <= 1'b0;
            avs_readdata <= '0;
        end else begin
            bus_ack      <= next_bus_ack;
            avs_readdata <= next_readdata;
        end
    end

    assign open_limit     = wwdt_limit(act_period);
    assign closed_limit   = wwdt_limit(act_window);
    assign open_reached   = wdt_tick && (14'(counter + 14'h0001) == open_limit);
    assign closed_reached = wdt_tick && (14'(counter + 14'h0001) == closed_limit);
    assign cfg_apply      = sync_pending_flag && wdt_tick && (2'(cfg_ticks + 2'h1) == wwdt_pkg::WWDT_SYNC_TICKS);
    assign restart_done   = rst_pend && wdt_tick && (2'(rst_ticks + 2'h1) == wwdt_pkg::WWDT_SYNC_TICKS);

    // configuration, lock and synchronisation
    always_comb begin
        next_watchdog_control  = watchdog_control;
        next_lock              = lock;
        next_armed             = armed;
        next_fuse_done         = 1'b1;
        next_sync_pending_flag = sync_pending_flag;
        next_cfg_ticks         = cfg_ticks;
        next_act_period        = act_period;
        next_act_window        = act_window;
        if (!fuse_done && fuse_enable) begin
            next_watchdog_control  = fuse_ctrl;
            next_lock              = 1'b1;
            next_sync_pending_flag = 1'b1;
            next_cfg_ticks         = 2'h0;
        end
        if (wr_taken) begin
            next_armed = 1'b0;
            if (armed && avs_byteenable[0]) begin
                if (reg_index == wwdt_pkg::WWDT_CTRL_INDEX && !lock && !sync_pending_flag) begin
                    next_watchdog_control  = avs_writedata[7:0];
                    next_sync_pending_flag = 1'b1;
                    next_cfg_ticks         = 2'h0;
                end
                if (reg_index == wwdt_pkg::WWDT_STATUS_INDEX) begin
                    if (avs_writedata[wwdt_pkg::WWDT_LOCK_BIT]) begin
                        next_lock = 1'b1;
                    end else if (debug_halt) begin
                        next_lock = 1'b0;
                    end
                end
            end
        end
        // the strobe wins over a write in the same cycle so an unlock is never lost
        if (config_change_guard) begin
            next_armed = 1'b1;
        end
        if (sync_pending_flag && wdt_tick) begin
            next_cfg_ticks = 2'(cfg_ticks + 2'h1);
        end
        if (cfg_apply) begin
            next_act_period        = watchdog_control[wwdt_pkg::WWDT_PERIOD_LSB +: wwdt_pkg::WWDT_CODE_WIDTH];
            next_act_window        = watchdog_control[wwdt_pkg::WWDT_WINDOW_LSB +: wwdt_pkg::WWDT_CODE_WIDTH];
            next_sync_pending_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            watchdog_control  <= wwdt_pkg::WWDT_CTRL_RESET;
            lock              <= 1'b0;
            armed             <= 1'b0;
            fuse_done         <= 1'b0;
            sync_pending_flag <= 1'b0;
            cfg_ticks         <= 2'h0;
            act_period        <= wwdt_pkg::WWDT_CODE_OFF;
            act_window        <= wwdt_pkg::WWDT_CODE_OFF;
        end else begin
            watchdog_control  <= next_watchdog_control;
            lock              <= next_lock;
            armed             <= next_armed;
            fuse_done         <= next_fuse_done;
            sync_pending_flag <= next_sync_pending_flag;
            cfg_ticks         <= next_cfg_ticks;
            act_period        <= next_act_period;
            act_window        <= next_act_window;
        end
    end

    // counting engine; no power-state input exists, so it never pauses for sleep
    always_comb begin
        next_state         = state;
        next_counter       = counter;
        next_rst_pend      = rst_pend;
        next_rst_ticks     = rst_ticks;
        next_reset_request = system_reset_request;
        if (rst_pend && wdt_tick) begin
            next_rst_ticks = 2'(rst_ticks + 2'h1);
        end
        if (restart_done) begin
            next_rst_pend = 1'b0;
        end
        if (watchdog_restart_instruction && !rst_pend && !debug_halt && state != wwdt_pkg::WWDT_OFF) begin
            next_rst_pend  = 1'b1;
            next_rst_ticks = 2'h0;
        end
        if (system_reset_request) begin
            next_state = state;
            if (debug_halt) begin
                next_counter = '0;
            end
        end else if (debug_halt) begin
            next_counter  = '0;
            next_rst_pend = 1'b0;
            if (act_period == wwdt_pkg::WWDT_CODE_OFF) begin
                next_state = wwdt_pkg::WWDT_OFF;
            end else if (act_window != wwdt_pkg::WWDT_CODE_OFF) begin
                next_state = wwdt_pkg::WWDT_FIRST;
            end else begin
                next_state = wwdt_pkg::WWDT_NORMAL;
            end
        end else if (cfg_apply) begin
            next_counter = '0;
            if (next_act_period == wwdt_pkg::WWDT_CODE_OFF) begin
                next_state = wwdt_pkg::WWDT_OFF;
            end else if (next_act_window != wwdt_pkg::WWDT_CODE_OFF) begin
                next_state = wwdt_pkg::WWDT_FIRST;
            end else begin
                next_state = wwdt_pkg::WWDT_NORMAL;
            end
        end else begin
            unique case (state)
                wwdt_pkg::WWDT_OFF: begin
                    next_counter = '0;
                end
                wwdt_pkg::WWDT_NORMAL, wwdt_pkg::WWDT_FIRST: begin
                    if (restart_done) begin
                        next_counter = '0;
                        if (state == wwdt_pkg::WWDT_FIRST) begin
                            next_state = wwdt_pkg::WWDT_CLOSED;
                        end
                    end else if (open_reached) begin
                        next_reset_request = 1'b1;
                    end else if (wdt_tick) begin
                        next_counter = 14'(counter + 14'h0001);
                    end
                end
                wwdt_pkg::WWDT_CLOSED: begin
                    if (restart_done) begin
                        next_reset_request = 1'b1;
                    end else if (closed_reached) begin
                        next_counter = '0;
                        next_state   = wwdt_pkg::WWDT_OPEN;
                    end else if (wdt_tick) begin
                        next_counter = 14'(counter + 14'h0001);
                    end
                end
                wwdt_pkg::WWDT_OPEN: begin
                    if (restart_done) begin
                        next_counter = '0;
                        next_state   = wwdt_pkg::WWDT_CLOSED;
                    end else if (open_reached) begin
                        next_reset_request = 1'b1;
                    end else if (wdt_tick) begin
                        next_counter = 14'(counter + 14'h0001);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state                <= wwdt_pkg::WWDT_OFF;
            counter              <= '0;
            rst_pend             <= 1'b0;
            rst_ticks            <= 2'h0;
            system_reset_request <= 1'b0;
        end else begin
            state                <= next_state;
            counter              <= next_counter;
            rst_pend             <= next_rst_pend;
            rst_ticks            <= next_rst_ticks;
            system_reset_request <= next_reset_request;
        end
    end

    property p_req_held;
        @(posedge clk) disable iff (srst) system_reset_request |=> system_reset_request;
    endproperty
    a_req_held: assert property (p_req_held) else $error("reset request dropped before reset");

    property p_halt_clears;
        @(posedge clk) disable iff (srst) debug_halt |=> counter == '0;
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("counter not cleared in debug halt");

    property p_timeout;
        @(posedge clk) disable iff (srst)
            (state == wwdt_pkg::WWDT_NORMAL && open_reached && !restart_done && !debug_halt && !cfg_apply)
            |=> system_reset_request;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out did not raise reset request");

    property p_early;
        @(posedge clk) disable iff (srst)
            (state == wwdt_pkg::WWDT_CLOSED && restart_done && !debug_halt && !cfg_apply) |=> system_reset_request;
    endproperty
    a_early: assert property (p_early) else $error("early restart not punished");

    property p_lock_freeze;
        @(posedge clk) disable iff (srst) (lock && fuse_done) |=> $stable(watchdog_control);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze) else $error("control changed while locked");

    property p_unprotected;
        @(posedge clk) disable iff (srst) (wr_taken && !armed && fuse_done) |=> $stable(watchdog_control) && $stable(lock);
    endproperty
    a_unprotected: assert property (p_unprotected) else $error("unprotected write took effect");

    property p_sync_hold;
        @(posedge clk) disable iff (srst) (sync_pending_flag && !wdt_tick) |=> $stable(act_period) && $stable(act_window);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("setting applied without counter tick");

    property p_first_closed;
        @(posedge clk) disable iff (srst)
            (state == wwdt_pkg::WWDT_FIRST) ##1 (state == wwdt_pkg::WWDT_CLOSED) |-> $past(restart_done);
    endproperty
    a_first_closed: assert property (p_first_closed) else $error("closed interval began without restart");

    property p_resume_normal;
        @(posedge clk) disable iff (srst)
            ($fell(debug_halt) && act_window != 4'h0 && act_period != 4'h0 && !system_reset_request && !$past(cfg_apply))
            |-> state == wwdt_pkg::WWDT_FIRST;
    endproperty
    a_resume_normal: assert property (p_resume_normal) else $error("resume did not run a normal time-out");

    property p_lock_stays;
        @(posedge clk) disable iff (srst) (lock && !debug_halt) |=> lock;
    endproperty
    a_lock_stays: assert property (p_lock_stays) else $error("lock cleared outside debug");
endmodule // wwdt_top

// [tb/wwdt_core_model.sv]
// core and low-power oscillator stand-in on the watchdog's far side
`timescale 1ns/10ps
module wwdt_core_model (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic kick,
    input  wire logic unlock,
    output logic      watchdog_counter_clock,
    output logic      watchdog_restart_instruction,
    output logic      config_change_guard
);
    logic [3:0] div = 4'h0;
    // oscillator runs free of reset; divided by 16 so long counts stay short
    always_ff @(posedge clk) begin
        div <= div + 4'h1;
        watchdog_restart_instruction <= ~srst & kick & ~watchdog_restart_instruction;
        config_change_guard <= ~srst & unlock & ~config_change_guard;
    end
    assign watchdog_counter_clock = div[3];
endmodule // wwdt_core_model

// [tb/wwdt_bench.sv]
// self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module wwdt_bench;
    logic        clk, srst, avs_read, avs_write, avs_waitrequest, kick, unlock;
    logic        debug_halt, fuse_enable, wcc, wri, ccg, req;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, seed, tmp;
    logic [7:0]  fuse_ctrl;
    int          fails = 0, total_checks = 0, cyc = 0, n;

    wwdt_top DUT (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .watchdog_counter_clock(wcc),
        .watchdog_restart_instruction(wri), .debug_halt(debug_halt), .config_change_guard(ccg),
        .fuse_ctrl(fuse_ctrl), .fuse_enable(fuse_enable), .system_reset_request(req));
    wwdt_core_model core (.clk(clk), .srst(srst), .kick(kick), .unlock(unlock),
        .watchdog_counter_clock(wcc), .watchdog_restart_instruction(wri), .config_change_guard(ccg));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task end_of_test;
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] r;
        @(posedge clk);
        r = rnd();
        avs_address <= a;
        avs_writedata <= {r[31:8], d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task gw(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) unlock <= 1'b1;
        @(posedge clk) unlock <= 1'b0;
        bus(1'b1, a, d, 4'hf);
    endtask
    task tk(input int k);
        repeat (k) @(posedge wcc);
        @(posedge clk);
    endtask
    task pulse;
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
    endtask
    task rst;
        @(posedge clk) srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
    endtask
    task meas(input int c);
        int lim;
        lim = 8 << (c - 1);
        gw(4'h0, 8'(c));
        n = 0;
        while (req !== 1'b1 && n < lim + 8) begin
            @(posedge wcc);
            repeat (6) @(posedge clk);
            n++;
        end
        total_checks++;
        if (n < lim || n > lim + 3) begin
            fails++;
            $display("unexpected timeout_ticks expected %0d seen %0d", lim + 2, n);
        end
        tk(10);
        chk("request_held", 1, req);
        rst;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            end_of_test;
        end
    end

    initial begin
        seed = 32'h693d0b60;
        srst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
        avs_byteenable = 4'hf; kick = 1'b0; unlock = 1'b0; debug_halt = 1'b0; fuse_enable = 1'b0;
        fuse_ctrl = 8'h00;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, 4'h0, 8'h00, 4'hf); chk("ctrl_reset", 0, rd);
        bus(1'b0, 4'h4, 8'h00, 4'hf); chk("status_reset", 0, rd);
        bus(1'b0, 4'h8, 8'h00, 4'hf); chk("unmapped", 0, rd);
        bus(1'b1, 4'h0, 8'h01, 4'hf); bus(1'b0, 4'h0, 8'h00, 4'hf); chk("plain_write", 0, rd);
        @(posedge clk) unlock <= 1'b1;
        @(posedge clk) unlock <= 1'b0;
        bus(1'b1, 4'h0, 8'h01, 4'he); bus(1'b0, 4'h0, 8'h00, 4'hf); chk("lane_off", 0, rd);
        gw(4'h0, 8'h01); bus(1'b0, 4'h4, 8'h00, 4'hf); chk("sync_busy", 1, rd);
        tk(3); bus(1'b0, 4'h4, 8'h00, 4'hf); chk("sync_done", 0, rd);
        bus(1'b0, 4'h0, 8'h00, 4'hf); chk("ctrl_value", 1, rd);
        rst;
        for (int c = 1; c <= 5; c++) meas(c);
        gw(4'h0, 8'h02);
        repeat (6) begin tk(8); pulse; end
        chk("kept_alive", 0, req);
        rst;
        gw(4'h0, 8'h11); tk(3); pulse; tk(4); chk("first_closed", 0, req);
        pulse; tk(5); chk("too_early", 1, req);
        rst;
        gw(4'h0, 8'h11); tk(3); pulse; tk(12); pulse; tk(6); chk("in_open", 0, req);
        tk(16); chk("too_late", 1, req);
        rst;
        gw(4'h0, 8'h01); tk(7); debug_halt <= 1'b1;
        tk(30); chk("halted", 0, req);
        debug_halt <= 1'b0; tk(5); chk("count_cleared", 0, req);
        tk(6); chk("resumed", 1, req);
        rst;
        gw(4'h0, 8'h11); tk(3); pulse; tk(3); debug_halt <= 1'b1; tk(2);
        debug_halt <= 1'b0; tk(1); pulse; tk(4); chk("resume_first", 0, req);
        rst;
        gw(4'h4, 8'h80); bus(1'b0, 4'h4, 8'h00, 4'hf); chk("lock_set", 32'h80, rd & 32'h80);
        gw(4'h0, 8'h05); tk(3); bus(1'b0, 4'h0, 8'h00, 4'hf); chk("locked_ctrl", 0, rd);
        debug_halt <= 1'b1;
        gw(4'h4, 8'h00); bus(1'b0, 4'h4, 8'h00, 4'hf); chk("lock_clear", 0, rd & 32'h80);
        debug_halt <= 1'b0;
        tmp = rnd();
        fuse_ctrl <= 8'(tmp % 11 + 1);
        fuse_enable <= 1'b1;
        rst;
        bus(1'b0, 4'h0, 8'h00, 4'hf); chk("fuse_ctrl", {24'h0, fuse_ctrl}, rd);
        bus(1'b0, 4'h4, 8'h00, 4'hf); chk("fuse_lock", 32'h80, rd & 32'h80);
        end_of_test;
    end
endmodule // wwdt_bench
